/* File: hw/dodt_ctrl.sv */
// Termination control: nominal and write strength, synchronous latency.
// Assumes pin and command inputs are sampled on the system clock edge.

module dodt_ctrl (
  // Clock and reset.
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst,
  // Pin and command inputs.
  input  wire logic                 i_odt,
  input  wire logic                 i_wr_cmd,
  input  wire logic                 i_wr_bc4,
  // Mode registers and latencies.
  input  wire dodt_pkg::dodt_mode_t i_mode,
  // Device state.
  input  wire logic                 i_dll_locked,
  input  wire logic                 i_dll_disable,
  input  wire logic                 i_cke,
  input  wire logic                 i_self_refresh,
  input  wire logic                 i_pd_active,
  input  wire logic                 i_pd_precharge,
  // Termination outputs.
  output logic                      o_rtt_on,
  output dodt_pkg::dodt_rtt_t       o_rtt_code,
  output logic                      o_rtt_wr_sel,
  output logic                      o_adc_undef,
  output logic                      o_sync_mode,
  output logic                      o_cfg_err
);

  // ==========================================================================
  // Decode functions
  // ==========================================================================
  function automatic dodt_pkg::dodt_rtt_t nom_dec(input logic [2:0] code);
    case (code)
      3'h1:    nom_dec = dodt_pkg::RTT_DIV4;
      3'h2:    nom_dec = dodt_pkg::RTT_DIV2;
      3'h3:    nom_dec = dodt_pkg::RTT_DIV6;
      3'h4:    nom_dec = dodt_pkg::RTT_DIV12;
      3'h5:    nom_dec = dodt_pkg::RTT_DIV8;
      default: nom_dec = dodt_pkg::RTT_OFF;
    endcase
  endfunction

  function automatic dodt_pkg::dodt_rtt_t wr_dec(input logic [1:0] code);
    case (code)
      2'h1:    wr_dec = dodt_pkg::RTT_DIV4;
      2'h2:    wr_dec = dodt_pkg::RTT_DIV2;
      default: wr_dec = dodt_pkg::RTT_OFF;
    endcase
  endfunction

  // ==========================================================================
  // Mode register fields
  // ==========================================================================
  wire logic [2:0] nom_code;
  wire logic [1:0] wr_code;
  wire logic [1:0] al_sel;
  wire logic       dll_pd_keep;
  wire logic       dyn_en;
  wire logic       nom_en;

  assign nom_code    = {i_mode.mr1[dodt_pkg::MR1_NOM_HI], i_mode.mr1[dodt_pkg::MR1_NOM_MID],
                        i_mode.mr1[dodt_pkg::MR1_NOM_LO]};
  assign wr_code     = {i_mode.mr2[dodt_pkg::MR2_WR_HI], i_mode.mr2[dodt_pkg::MR2_WR_LO]};
  assign al_sel      = {i_mode.mr1[dodt_pkg::MR1_AL_HI], i_mode.mr1[dodt_pkg::MR1_AL_LO]};
  assign dll_pd_keep = i_mode.mr0[dodt_pkg::MR0_DLL_PD];
  assign dyn_en      = wr_code != dodt_pkg::WR_OFF;
  assign nom_en      = nom_code != dodt_pkg::NOM_OFF;

  // ==========================================================================
  // Latency arithmetic
  // ==========================================================================
  wire logic [4:0] al_ck;
  wire logic [4:0] wl_ck;
  wire logic [4:0] odtl_ck;
  wire logic [4:0] tap_on;
  wire logic [4:0] tap_bc4;
  wire logic [4:0] tap_bl8;

  // Additive latency feeds both write latency and the pin delay.
  assign al_ck   = (al_sel == dodt_pkg::AL_SEL_M1) ? i_mode.cl - dodt_pkg::AL_CL_M1 :
                   (al_sel == dodt_pkg::AL_SEL_M2) ? i_mode.cl - dodt_pkg::AL_CL_M2 :
                   dodt_pkg::AL_ZERO;
  assign wl_ck   = i_mode.cwl + al_ck;
  assign odtl_ck = wl_ck - dodt_pkg::ODTL_SUB;
  // Two pipeline stages sit between the history and the outputs.
  assign tap_on  = odtl_ck - dodt_pkg::TAP_SKEW;
  assign tap_bc4 = odtl_ck + dodt_pkg::BC4_END_CK - dodt_pkg::TAP_SKEW;
  assign tap_bl8 = odtl_ck + dodt_pkg::BL8_END_CK - dodt_pkg::TAP_SKEW;

  // ==========================================================================
  // Operating mode
  // ==========================================================================
  wire logic pin_ignore;
  wire logic sync_w;

  assign pin_ignore = i_self_refresh | i_dll_disable | (!nom_en & !dyn_en);
  assign sync_w     = i_dll_locked & !i_dll_disable & (nom_en | dyn_en) &
                      (i_cke | i_pd_active | (i_pd_precharge & dll_pd_keep));

  // ==========================================================================
  // Sample history
  // ==========================================================================
  dodt_pkg::dodt_hist_t hist_in;
  dodt_pkg::dodt_hist_t rd_on;
  dodt_pkg::dodt_hist_t rd_bc4;
  dodt_pkg::dodt_hist_t rd_bl8;

  // Writes without dynamic termination leave the strength nominal.
  assign hist_in = {i_odt, i_wr_cmd & i_wr_bc4 & dyn_en, i_wr_cmd & !i_wr_bc4 & dyn_en};

  dodt_hist u_hist (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_wdata   (hist_in),
    .i_tap_a   (tap_on),
    .i_tap_b   (tap_bc4),
    .i_tap_c   (tap_bl8),
    .o_rd_a    (rd_on),
    .o_rd_b    (rd_bc4),
    .o_rd_c    (rd_bl8)
  );

  // ==========================================================================
  // Termination state
  // ==========================================================================
  wire logic                wr_start;
  wire logic                wr_end;
  wire logic [4:0]          start_len;
  wire logic [4:0]          rem_dec;
  wire logic [4:0]          rem_d;
  logic      [4:0]          rem_q;
  wire logic                wr_act_d;
  wire logic                on_d;
  wire logic                adc_d;
  wire logic                err_d;
  wire dodt_pkg::dodt_rtt_t code_d;

  assign wr_start = rd_on.wr_bc4 | rd_on.wr_bl8;
  assign wr_end   = rd_bc4.wr_bc4 | rd_bl8.wr_bl8;
  // Overlapping bursts keep the longest remaining window; leaving sync mode clears it.
  assign start_len = !wr_start ? 5'h00 :
                     rd_on.wr_bl8 ? dodt_pkg::BL8_END_CK : dodt_pkg::BC4_END_CK;
  assign rem_dec   = (rem_q != 5'h00) ? rem_q - 5'h01 : 5'h00;
  assign rem_d     = !sync_w ? 5'h00 : (start_len > rem_dec) ? start_len : rem_dec;
  assign wr_act_d  = rem_d != 5'h00;
  // Outside synchronous mode the pin bypasses the history and reaches the output one clock later.
  assign on_d     = !pin_ignore & (sync_w ? rd_on.odt : i_odt);
  assign code_d   = !on_d ? dodt_pkg::RTT_OFF :
                    wr_act_d ? wr_dec(wr_code) : nom_dec(nom_code);
  assign adc_d    = on_d & (wr_act_d != o_rtt_wr_sel);
  assign err_d    = (nom_code > dodt_pkg::NOM_DIV8) | (wr_code == dodt_pkg::WR_RSV) |
                    (al_sel == dodt_pkg::AL_SEL_RSV) |
                    (((nom_code == dodt_pkg::NOM_DIV12) | (nom_code == dodt_pkg::NOM_DIV8)) &
                     (i_self_refresh | (on_d & !wr_act_d & i_wr_cmd)));

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rtt_on     <= 1'b0;
      o_rtt_code   <= dodt_pkg::RTT_OFF;
      o_rtt_wr_sel <= 1'b0;
      o_adc_undef  <= 1'b0;
      o_sync_mode  <= 1'b0;
      o_cfg_err    <= 1'b0;
      rem_q        <= 5'h00;
    end else begin
      o_rtt_on     <= on_d;
      o_rtt_code   <= code_d;
      o_rtt_wr_sel <= wr_act_d;
      o_adc_undef  <= adc_d;
      o_sync_mode  <= sync_w;
      o_cfg_err    <= err_d;
      rem_q        <= rem_d;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  wire logic chk_c;

  assign chk_c = sync_w & !pin_ignore & (i_mode.cwl == 5'h05) & (al_sel == 2'h0);

  sr_ignore_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_self_refresh |=> !o_rtt_on && o_rtt_code == dodt_pkg::RTT_OFF)
    else $error("Termination active after self refresh entry.");

  dll_off_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_dll_disable |=> !o_rtt_on && !o_sync_mode && !o_rtt_wr_sel)
    else $error("Termination active with DLL disabled.");

  pd_active_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_pd_active && i_dll_locked && !i_dll_disable && (nom_en || dyn_en)) |=> o_sync_mode)
    else $error("Active power-down left synchronous mode.");

  pd_precharge_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_pd_precharge && !i_pd_active && !i_cke && !dll_pd_keep) |=> !o_sync_mode)
    else $error("Precharge power-down without DLL stayed synchronous.");

  wr_code_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_rtt_on && o_rtt_wr_sel) |-> o_rtt_code == wr_dec($past(wr_code)))
    else $error("Write strength does not match write field.");

  nom_code_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_rtt_on && !o_rtt_wr_sel) |-> o_rtt_code == nom_dec($past(nom_code)))
    else $error("Nominal strength does not match nominal field.");

  adc_window_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ($changed(o_rtt_wr_sel) && o_rtt_on) |-> o_adc_undef)
    else $error("Strength change without undefined window.");

  odt_latency_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ($rose(i_odt) && chk_c) ##1 chk_c ##1 chk_c |=> o_rtt_on)
    else $error("Termination not on three clocks after pin high.");

  wr_start_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_wr_cmd && dyn_en && chk_c) ##1 chk_c ##1 chk_c |=> o_rtt_wr_sel)
    else $error("Write strength not selected at write latency minus two.");

  bc4_end_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_wr_cmd && i_wr_bc4 && dyn_en && chk_c) ##1 (!i_wr_cmd && chk_c)[*6] |=> !o_rtt_wr_sel)
    else $error("Burst-chop write strength not released.");

  bl8_end_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_wr_cmd && !i_wr_bc4 && dyn_en && chk_c) ##1 (!i_wr_cmd && chk_c)[*8] |=> !o_rtt_wr_sel)
    else $error("Burst-length-8 write strength not released.");

  win_end_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    chk_c[*7] ##0 wr_end |-> o_rtt_wr_sel)
    else $error("Write window closed before its burst end.");

endmodule

/* File: include/dodt_pkg.sv */
// Shared constants and types for the dynamic termination controller.
// Assumes mode register words are supplied whole and held stable by the controller.
package dodt_pkg;

  // ==========================================================================
  // History depth and latency arithmetic
  // ==========================================================================
  localparam int unsigned HIST_DEPTH = 32;
  localparam int unsigned HIST_AW    = 5;
  localparam logic [4:0]  ODTL_SUB   = 5'h02;
  localparam logic [4:0]  TAP_SKEW   = 5'h03;
  localparam logic [4:0]  BC4_END_CK = 5'h04;
  localparam logic [4:0]  BL8_END_CK = 5'h06;
  localparam logic [4:0]  AL_CL_M1   = 5'h01;
  localparam logic [4:0]  AL_CL_M2   = 5'h02;
  localparam logic [4:0]  AL_ZERO    = 5'h00;

  // ==========================================================================
  // Mode register field positions
  // ==========================================================================
  localparam int unsigned MR0_DLL_PD   = 12;
  localparam int unsigned MR1_NOM_HI   = 9;
  localparam int unsigned MR1_NOM_MID  = 6;
  localparam int unsigned MR1_NOM_LO   = 2;
  localparam int unsigned MR1_AL_HI    = 4;
  localparam int unsigned MR1_AL_LO    = 3;
  localparam int unsigned MR2_WR_HI    = 10;
  localparam int unsigned MR2_WR_LO    = 9;

  // ==========================================================================
  // Field encodings
  // ==========================================================================
  localparam logic [1:0] AL_SEL_M1  = 2'h1;
  localparam logic [1:0] AL_SEL_M2  = 2'h2;
  localparam logic [1:0] AL_SEL_RSV = 2'h3;
  localparam logic [2:0] NOM_OFF    = 3'h0;
  localparam logic [2:0] NOM_DIV12  = 3'h4;
  localparam logic [2:0] NOM_DIV8   = 3'h5;
  localparam logic [1:0] WR_OFF     = 2'h0;
  localparam logic [1:0] WR_RSV     = 2'h3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    RTT_OFF,
    RTT_DIV2,
    RTT_DIV4,
    RTT_DIV6,
    RTT_DIV8,
    RTT_DIV12
  } dodt_rtt_t;

  typedef struct packed {
    logic odt;
    logic wr_bc4;
    logic wr_bl8;
  } dodt_hist_t;

  typedef struct packed {
    logic [15:0] mr0;
    logic [15:0] mr1;
    logic [15:0] mr2;
    logic [4:0]  cl;
    logic [4:0]  cwl;
  } dodt_mode_t;

endpackage

/* File: hw/dodt_hist.sv */
// Sample history of the termination pin and write commands, with three taps.
// Assumes tap indices are below the history depth.
module dodt_hist (
  // Clock and reset.
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_rst,
  // New sample.
  input  wire dodt_pkg::dodt_hist_t           i_wdata,
  // Tap indices.
  input  wire logic [dodt_pkg::HIST_AW-1:0]   i_tap_a,
  input  wire logic [dodt_pkg::HIST_AW-1:0]   i_tap_b,
  input  wire logic [dodt_pkg::HIST_AW-1:0]   i_tap_c,
  // Registered tap data.
  output dodt_pkg::dodt_hist_t                o_rd_a,
  output dodt_pkg::dodt_hist_t                o_rd_b,
  output dodt_pkg::dodt_hist_t                o_rd_c
);

  // ==========================================================================
  // Shift history
  // ==========================================================================
  dodt_pkg::dodt_hist_t mem_q [dodt_pkg::HIST_DEPTH];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < dodt_pkg::HIST_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      o_rd_a <= '0;
      o_rd_b <= '0;
      o_rd_c <= '0;
    end else begin
      mem_q[0] <= i_wdata;
      for (int i = 1; i < dodt_pkg::HIST_DEPTH; i++) begin
        mem_q[i] <= mem_q[i-1];
      end
      o_rd_a <= mem_q[i_tap_a];
      o_rd_b <= mem_q[i_tap_b];
      o_rd_c <= mem_q[i_tap_c];
    end
  end

endmodule

/* File: testbench/dodt_host_model.sv */
// Memory controller model: drives the termination pin and write commands.
// Assumes the bench supplies a fresh random word on every rising clock edge.
module dodt_host_model (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Traffic control.
  input  wire logic        i_en,
  input  wire logic        i_wr_en,
  input  wire logic [31:0] i_rnd,
  // Pin and command outputs.
  output logic             o_odt    = 1'b0,
  output logic             o_wr_cmd = 1'b0,
  output logic             o_wr_bc4 = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  int   hold = 0;
  int   gap  = 0;
  int   need;
  logic wr_go;

  // ==========================================================================
  // Traffic generation
  // ==========================================================================
  always @(posedge i_sys_clk) begin
    #1;
    need = i_rnd[6] ? 4 : 6;
    hold = (hold > 0) ? hold - 1 : 0;
    gap = (gap > 0) ? gap - 1 : 0;
    wr_go = 1'b0;
    if (i_rst) begin
      o_odt = 1'b0;
      hold = 0;
    end else if (o_odt && hold == 0 && (!i_en || i_rnd[2:0] == 3'h0)) begin
      o_odt = 1'b0;
    end else if (!o_odt && i_en && i_rnd[1:0] == 2'h0) begin
      o_odt = 1'b1;
      hold = 4;
    end else if (i_en && i_wr_en && gap == 0 && i_rnd[5:4] == 2'h0) begin
      wr_go = 1'b1; // Only writes are issued, so no read burst meets the pin
      o_wr_bc4 = i_rnd[6];
      gap = 4;
      hold = (o_odt && need > hold) ? need : hold;
    end
    o_wr_cmd = wr_go;
  end
endmodule

/* File: testbench/dodt_ctrl_tb_top.sv */
// Self-checking bench comparing the termination controller with a model.
// Assumes the controller model module is compiled before this file.
module dodt_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals and reference state
  // ==========================================================================
  logic                 i_sys_clk, odt, wr, bc4, rtt_on, wr_sel, undef, sync, cfg_err;
  logic                 i_rst = 1'b1, run = 1'b0, wen = 1'b0, locked = 1'b0, dlldis = 1'b0;
  logic                 cke = 1'b0, sr = 1'b0, pda = 1'b0, pdp = 1'b0;
  logic [31:0]          lfsr_q = 32'hBC918997;
  dodt_pkg::dodt_mode_t mode = '0;
  dodt_pkg::dodt_rtt_t  code, ncd, wcd, ecode;
  int                   mismatches, checked, cyc, chk, lat;
  logic                 ign, dyn, esyn, eerr, eon, esel, pon, psel, syn_chk;
  logic                 oh [$];
  int                   wl [$];
  dodt_pkg::dodt_rtt_t  ntab [8] = '{dodt_pkg::RTT_OFF, dodt_pkg::RTT_DIV4, dodt_pkg::RTT_DIV2,
    dodt_pkg::RTT_DIV6, dodt_pkg::RTT_DIV12, dodt_pkg::RTT_DIV8, dodt_pkg::RTT_OFF,
    dodt_pkg::RTT_OFF};
  dodt_pkg::dodt_rtt_t  wtab [4] = '{dodt_pkg::RTT_OFF, dodt_pkg::RTT_DIV4, dodt_pkg::RTT_DIV2,
    dodt_pkg::RTT_OFF};

  dodt_host_model host_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_en(run), .i_wr_en(wen),
    .i_rnd(lfsr_q), .o_odt(odt), .o_wr_cmd(wr), .o_wr_bc4(bc4));

  dodt_ctrl dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_odt(odt), .i_wr_cmd(wr),
    .i_wr_bc4(bc4), .i_mode(mode), .i_dll_locked(locked), .i_dll_disable(dlldis),
    .i_cke(cke), .i_self_refresh(sr), .i_pd_active(pda), .i_pd_precharge(pdp),
    .o_rtt_on(rtt_on), .o_rtt_code(code), .o_rtt_wr_sel(wr_sel), .o_adc_undef(undef),
    .o_sync_mode(sync), .o_cfg_err(cfg_err));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_code(input dodt_pkg::dodt_rtt_t got, input dodt_pkg::dodt_rtt_t exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares results against the pin and write history of the model; on, select and code only when chk is 2.
  task automatic check_cycle();
    eon = ign ? 1'b0 : oh[lat];
    esel = 1'b0;
    for (int i = lat; i < lat + 6; i++) begin
      if (dyn && esyn && wl[i] != 0 && i < lat + wl[i]) esel = 1'b1;
    end
    ecode = !eon ? dodt_pkg::RTT_OFF : (esel ? wcd : ncd);
    if (chk == 2) begin
      cmp_bit(rtt_on, eon);
      cmp_bit(wr_sel, esel);
      cmp_code(code, ecode);
      if (eon && pon) cmp_bit(undef, esel ^ psel);
    end
    if (syn_chk) cmp_bit(sync, esyn);
    cmp_bit(cfg_err, eerr | (eon && !esel && wl[1] != 0 && (ncd == dodt_pkg::RTT_DIV12 ||
      ncd == dodt_pkg::RTT_DIV8)));
    pon = eon;
    psel = esel;
  endtask

  // Programs one configuration, lets the history settle, then runs traffic.
  task automatic phase(input int nom, wrc, al, cwl, lk, st, we, md);
    @(posedge i_sys_clk);
    #1;
    chk = 0;
    run = 1'b0;
    wen = 1'b0;
    pon = 1'b0;
    mode = {lfsr_q[15:0], lfsr_q[31:16], lfsr_q[15:0], 5'(cwl + 1), 5'(cwl)};
    {mode.mr1[9], mode.mr1[6], mode.mr1[2]} = 3'(nom);
    mode.mr1[4:3] = 2'(al);
    mode.mr2[10:9] = 2'(wrc);
    mode.mr0[12] = (st == 2);
    cke = (st == 0);
    pda = (st == 1);
    pdp = (st == 2 || st == 3);
    sr = (st == 4);
    dlldis = (st == 5);
    locked = (lk != 0 && st != 5);
    lat = cwl - 2 + ((al == 1) ? cwl : (al == 2) ? cwl - 1 : 0);
    ign = (st >= 4 || (nom == 0 && wrc == 0));
    esyn = locked && (nom != 0 || wrc != 0) && st <= 2;
    lat = esyn ? lat : 1;
    dyn = (wrc != 0);
    ncd = ntab[nom];
    wcd = wtab[wrc];
    eerr = (nom >= 6 || wrc == 3 || al == 3 || (st == 4 && (nom == 4 || nom == 5)));
    syn_chk = (md == 2 && st != 4);
    repeat (30) @(posedge i_sys_clk);
    #1;
    chk = md;
    run = 1'b1;
    wen = (we != 0);
    repeat (150) @(posedge i_sys_clk);
  endtask

  // ==========================================================================
  // Clock, monitor and main sequence
  // ==========================================================================
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    lfsr_q <= lfsr_next(lfsr_q);
    if (!i_rst) begin
      cyc++;
      oh.push_front(odt);
      wl.push_front(wr ? (bc4 ? 4 : 6) : 0);
      if (oh.size() > 40) begin
        void'(oh.pop_back());
        void'(wl.pop_back());
      end
      if (chk != 0) check_cycle();
      if (cyc == 5000) begin
        mismatches++;
        complete_run();
      end
    end
  end

  initial begin
    repeat (3) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    phase(1, 0, 0, 5, 1, 0, 1, 2);
    phase(2, 1, 0, 5, 1, 0, 1, 2);
    phase(3, 2, 1, 6, 1, 0, 1, 2);
    phase(1, 2, 2, 7, 1, 0, 1, 2);
    phase(4, 1, 3, 9, 1, 0, 0, 2);
    phase(0, 2, 0, 5, 1, 0, 1, 2);
    phase(0, 0, 0, 5, 1, 0, 1, 2);
    phase(5, 1, 0, 5, 0, 0, 1, 2);
    phase(2, 1, 0, 6, 1, 1, 0, 2);
    phase(2, 1, 0, 6, 1, 2, 0, 2);
    phase(2, 1, 0, 6, 1, 3, 0, 2);
    phase(4, 0, 0, 5, 1, 4, 0, 2);
    phase(2, 0, 0, 5, 1, 5, 0, 2);
    phase(6, 1, 0, 5, 1, 0, 0, 1);
    phase(7, 2, 0, 5, 1, 0, 0, 1);
    phase(1, 3, 0, 5, 1, 0, 0, 1);
    complete_run();
  end
endmodule
